//--- logic/string_compare_translate_unit.sv
// byte-string instruction engine: translate-until-escape, compares, scan/span
// assumes a sequencer that pulses start with operands and a one-byte memory port
// that answers a read or write with mem_ack after any number of cycles
// What this block does
// - opcode 2F is translate-until-escape with six operands
// - each source byte indexes a 256-byte table; entry written to destination
// - translation stops on escape match, source end or destination end
// - overflow set on escape stop, cleared otherwise
// - overlapping destination gives undefined results; no protection needed
// - R0 holds unconsumed source bytes including the escaping byte
// - R1 points at stopping source byte, R2 zero, R3 table address
// - R4 unused destination count, R5 next destination address
// - opcode 29 compares with one length, 2D with two lengths and fill
// - compare walks bytes upward, stops at first unequal pair
// - flags from last pair: signed less, equal, unsigned less, V clear
// - five-operand compare pads the shorter string with the fill byte
// - three-operand: R0=R2 remaining, R1/R3 at terminating bytes
// - five-operand: R0/R2 remaining counts, R1/R3 terminating or past end
// - two empty strings give Z set and N, V, C clear
// - opcodes 2A/2B index a 256-entry table, entry ANDed with mask
// - scan stops on nonzero masked entry, span on zero
// - scan/span clear Z on stop found, else set; N V C clear
// - scan/span: R0 remaining, R1 stop address, R2 zero, R3 table
// - empty string for scan/span leaves Z set
// - strings are a 16-bit unsigned length and lowest byte address
// - pending interrupt saves progress, sets first_part_done, resumes later
`timescale 1ns/100ps
`default_nettype none
`include "string_unit_cfg.svh"
module string_compare_translate_unit (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // sequencer side
  input wire logic start_in,
  input wire string_unit_pkg::operands_s operands_in,
  input wire logic resume_in,
  input wire logic interrupt_pending_in,
  output logic busy_out,
  output logic done_out,
  output logic illegal_op_out,
  output logic first_part_done_out,
  output string_unit_pkg::flags_s flags_out,
  output logic [31:0] r0_out,
  output logic [31:0] r1_out,
  output logic [31:0] r2_out,
  output logic [31:0] r3_out,
  output logic [31:0] r4_out,
  output logic [31:0] r5_out,
  // memory port
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  string_unit_pkg::state_e state;
  logic [7:0] op;
  logic [15:0] len1;
  logic [15:0] len2;
  logic [31:0] addr1;
  logic [31:0] addr2;
  logic [31:0] tbl;
  logic [7:0] aux;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] tbyte;
  logic stop_hit;
  logic is_tr;
  logic is_c3;
  logic is_c5;
  logic is_cls;
  logic op_ok;
  logic s1_left;
  logic s2_left;
  logic more;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic masked_zero;
  logic class_stop;

  assign is_tr = (op == `OP_TRANSLATE_ESC);
  assign is_c3 = (op == `OP_CMP_THREE);
  assign is_c5 = (op == `OP_CMP_FIVE);
  assign is_cls = (op == `OP_CLASS_SCAN) || (op == `OP_CLASS_SPAN);
  assign op_ok = (operands_in.opcode == `OP_TRANSLATE_ESC) ||
                 (operands_in.opcode == `OP_CMP_THREE) ||
                 (operands_in.opcode == `OP_CMP_FIVE) ||
                 (operands_in.opcode == `OP_CLASS_SCAN) ||
                 (operands_in.opcode == `OP_CLASS_SPAN);
  assign s1_left = (len1 != 16'h0000);
  assign s2_left = (len2 != 16'h0000);
  // work remains while either string has bytes (five-operand), both do (translate), or the first does
  always_comb begin
    if (is_c5) begin
      more = s1_left || s2_left;
    end else if (is_tr) begin
      more = s1_left && s2_left;
    end else begin
      more = s1_left;
    end
  end
  // padded compare operands
  assign cmp_a = s1_left ? byte1 : aux;
  assign cmp_b = (is_c5 && !s2_left) ? aux : byte2;
  assign masked_zero = ((tbyte & aux) == 8'h00);
  assign class_stop = (op == `OP_CLASS_SCAN) ? !masked_zero : masked_zero;

  // sequencing
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= string_unit_pkg::ST_IDLE;
    end else begin
      case (state)
        string_unit_pkg::ST_IDLE: begin
          if (start_in && op_ok) begin
            state <= string_unit_pkg::ST_STEP;
          end else if (resume_in) begin
            state <= string_unit_pkg::ST_STEP;
          end
        end
        string_unit_pkg::ST_STEP: begin
          if (!more) begin
            state <= string_unit_pkg::ST_DONE;
          end else if (interrupt_pending_in) begin
            state <= string_unit_pkg::ST_IDLE;
          end else if (is_c5 && !s1_left) begin
            state <= string_unit_pkg::ST_RD2;
          end else begin
            state <= string_unit_pkg::ST_RD1;
          end
        end
        string_unit_pkg::ST_RD1: begin
          if (mem_ack_in) begin
            if (is_tr || is_cls) begin
              state <= string_unit_pkg::ST_RDT;
            end else if (is_c5 && !s2_left) begin
              state <= string_unit_pkg::ST_WR;
            end else begin
              state <= string_unit_pkg::ST_RD2;
            end
          end
        end
        string_unit_pkg::ST_RD2: begin
          if (mem_ack_in) begin
            state <= string_unit_pkg::ST_WR;
          end
        end
        string_unit_pkg::ST_RDT: begin
          if (mem_ack_in) begin
            state <= string_unit_pkg::ST_WR;
          end
        end
        string_unit_pkg::ST_WR: begin
          // translate writes here; others only evaluate the byte
          if (is_tr) begin
            if (tbyte == aux) begin
              state <= string_unit_pkg::ST_DONE;
            end else if (mem_ack_in) begin
              state <= string_unit_pkg::ST_STEP;
            end
          end else if (is_cls) begin
            state <= class_stop ? string_unit_pkg::ST_DONE : string_unit_pkg::ST_STEP;
          end else begin
            state <= (cmp_a != cmp_b) ? string_unit_pkg::ST_DONE : string_unit_pkg::ST_STEP;
          end
        end
        string_unit_pkg::ST_DONE: begin
          state <= string_unit_pkg::ST_IDLE;
        end
        default: begin
          state <= string_unit_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // operand and progress registers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op <= 8'h00;
      len1 <= 16'h0000;
      len2 <= 16'h0000;
      addr1 <= 32'h0000_0000;
      addr2 <= 32'h0000_0000;
      tbl <= 32'h0000_0000;
      aux <= 8'h00;
    end else if (state == string_unit_pkg::ST_IDLE && start_in && op_ok) begin
      op <= operands_in.opcode;
      len1 <= operands_in.len1;
      addr1 <= operands_in.addr1;
      len2 <= (operands_in.opcode == `OP_CMP_THREE) ? operands_in.len1 : operands_in.len2;
      addr2 <= operands_in.addr2;
      tbl <= operands_in.table_addr;
      aux <= operands_in.aux_byte;
    end else if (state == string_unit_pkg::ST_WR) begin
      // advance the strings past a consumed byte (only the source for scan/span), unless it stops the walk
      if (is_tr && tbyte != aux && mem_ack_in) begin
        len1 <= len1 - 16'h0001;
        addr1 <= addr1 + 32'h0000_0001;
        len2 <= len2 - 16'h0001;
        addr2 <= addr2 + 32'h0000_0001;
      end else if (is_cls && !class_stop) begin
        len1 <= len1 - 16'h0001;
        addr1 <= addr1 + 32'h0000_0001;
      end else if ((is_c3 || is_c5) && cmp_a == cmp_b) begin
        if (s1_left) begin
          len1 <= len1 - 16'h0001;
          addr1 <= addr1 + 32'h0000_0001;
        end
        if (s2_left) begin
          len2 <= len2 - 16'h0001;
          addr2 <= addr2 + 32'h0000_0001;
        end
      end
    end
  end

  // fetched bytes
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      tbyte <= 8'h00;
    end else if (mem_ack_in) begin
      if (state == string_unit_pkg::ST_RD1) begin
        byte1 <= mem_rdata_in;
      end
      if (state == string_unit_pkg::ST_RD2) begin
        byte2 <= mem_rdata_in;
      end
      if (state == string_unit_pkg::ST_RDT) begin
        tbyte <= mem_rdata_in;
      end
    end
  end

  // stop cause for translate
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stop_hit <= 1'b0;
    end else if (state == string_unit_pkg::ST_IDLE && start_in) begin
      stop_hit <= 1'b0;
    end else if (state == string_unit_pkg::ST_WR) begin
      stop_hit <= is_tr ? (tbyte == aux) : (is_cls ? class_stop : 1'b0);
    end
  end

  // condition flags, default for empty strings is the equal case
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_out <= '0;
    end else if (state == string_unit_pkg::ST_IDLE && start_in && op_ok) begin
      flags_out <= 4'b0100;
    end else if (state == string_unit_pkg::ST_WR && (is_c3 || is_c5)) begin
      flags_out.n <= ($signed(cmp_a) < $signed(cmp_b));
      flags_out.z <= (cmp_a == cmp_b);
      flags_out.v <= 1'b0;
      flags_out.c <= (cmp_a < cmp_b);
    end else if (state == string_unit_pkg::ST_WR && is_cls) begin
      flags_out <= {1'b0, !class_stop, 2'b00};
    end else if (state == string_unit_pkg::ST_DONE && is_tr) begin
      // escape sets V; z/c report remaining lengths for the software tests
      flags_out.n <= 1'b0;
      flags_out.z <= (len1 == len2);
      flags_out.v <= stop_hit;
      flags_out.c <= (len1 < len2);
    end
  end

  // interrupted-instruction marker
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      first_part_done_out <= 1'b0;
    end else if (state == string_unit_pkg::ST_STEP && more && interrupt_pending_in) begin
      first_part_done_out <= 1'b1;
    end else if (state == string_unit_pkg::ST_IDLE && (resume_in || start_in)) begin
      first_part_done_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      illegal_op_out <= 1'b0;
    end else begin
      done_out <= (state == string_unit_pkg::ST_DONE);
      illegal_op_out <= (state == string_unit_pkg::ST_IDLE) && start_in && !op_ok;
    end
  end

  // memory port; overlapping destinations are not guarded
  always_comb begin
    mem_req_out = 1'b0;
    mem_we_out = 1'b0;
    mem_addr_out = 32'h0000_0000;
    mem_wdata_out = tbyte;
    case (state)
      string_unit_pkg::ST_RD1: begin
        mem_req_out = 1'b1;
        mem_addr_out = addr1;
      end
      string_unit_pkg::ST_RD2: begin
        mem_req_out = 1'b1;
        mem_addr_out = addr2;
      end
      string_unit_pkg::ST_RDT: begin
        mem_req_out = 1'b1;
        mem_addr_out = tbl + {24'h000000, byte1};
      end
      string_unit_pkg::ST_WR: begin
        mem_req_out = is_tr && (tbyte != aux);
        mem_we_out = is_tr && (tbyte != aux);
        mem_addr_out = addr2;
      end
      default: begin
        mem_req_out = 1'b0;
      end
    endcase
  end

  // progress registers as seen by software
  assign busy_out = (state != string_unit_pkg::ST_IDLE);
  assign r0_out = {16'h0000, len1};
  assign r1_out = addr1;
  assign r2_out = (is_tr || is_cls) ? 32'h0000_0000 : {16'h0000, len2};
  assign r3_out = (is_tr || is_cls) ? tbl : addr2;
  assign r4_out = is_tr ? {16'h0000, len2} : 32'h0000_0000;
  assign r5_out = is_tr ? addr2 : 32'h0000_0000;

  // checks
  sequence s_escape_write;
    state == string_unit_pkg::ST_WR && is_tr && tbyte == aux;
  endsequence
  chk_escape_sets_v: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    s_escape_write |=> ##1 flags_out.v)
    else $error("escape did not set overflow");
  chk_escape_no_write: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    s_escape_write |-> !mem_we_out)
    else $error("escaping byte was written");
  chk_cmp_v_clear: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_WR && is_c3) |=> !flags_out.v)
    else $error("compare left overflow set");
  chk_cmp_stop_neq: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_WR && is_c3 && cmp_a != cmp_b) |=> state == string_unit_pkg::ST_DONE)
    else $error("compare did not stop on mismatch");
  chk_class_z: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_WR && is_cls && class_stop) |=> !flags_out.z && !flags_out.n)
    else $error("scan/span stop left zero set");
  chk_empty_z: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_IDLE && start_in && op_ok && operands_in.len1 == 16'h0000
     && operands_in.opcode == `OP_CLASS_SCAN) |=> ##2 flags_out.z)
    else $error("empty scan cleared zero");
  chk_tr_r2_zero: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (done_out && is_tr) |-> r2_out == 32'h0000_0000 && r3_out == tbl)
    else $error("translate r2/r3 wrong");
  chk_fpd_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_STEP && more && interrupt_pending_in)
    |=> first_part_done_out && state == string_unit_pkg::ST_IDLE)
    else $error("interrupt did not save progress");
  chk_table_index: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_RDT) |-> mem_addr_out == tbl + {24'h000000, byte1})
    else $error("table index wrong");
  sequence s_translate_store;
    state == string_unit_pkg::ST_WR && is_tr && tbyte != aux && mem_ack_in;
  endsequence
  chk_tr_counts_step: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    s_translate_store |=> len1 == $past(len1) - 16'h0001 && len2 == $past(len2) - 16'h0001)
    else $error("translate store did not consume one byte of each string");
  chk_span_stop: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state == string_unit_pkg::ST_WR && op == `OP_CLASS_SPAN && masked_zero)
    |=> state == string_unit_pkg::ST_DONE && !flags_out.z)
    else $error("span did not stop on zero masked entry");
endmodule
`default_nettype wire

//--- logic/string_unit_cfg.svh
// constants for the string compare / translate unit
// assumes inclusion by bare name from the design file
`ifndef STRING_UNIT_CFG_SVH
`define STRING_UNIT_CFG_SVH
`define OP_TRANSLATE_ESC 8'h2F
`define OP_CMP_THREE 8'h29
`define OP_CMP_FIVE 8'h2D
`define OP_CLASS_SCAN 8'h2A
`define OP_CLASS_SPAN 8'h2B
`define TABLE_ENTRIES 9'h100
`endif

//--- logic/string_unit_pkg.sv
// types for the string compare / translate unit
// assumes string_unit_cfg.svh on the include path
package string_unit_pkg;
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] len1;
    logic [31:0] addr1;
    logic [15:0] len2;
    logic [31:0] addr2;
    logic [31:0] table_addr;
    logic [7:0] aux_byte;
  } operands_s;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD1, ST_RD2, ST_RDT, ST_WR, ST_STEP, ST_DONE
  } state_e;
endpackage

//--- verif/string_compare_translate_unit_tb.sv
// self-checking bench for the string compare / translate unit
// assumes string_mem_model as the memory behind the unit
`timescale 1ns/100ps
`default_nettype none
module string_compare_translate_unit_tb;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic start = 1'b0, resume = 1'b0, intr = 1'b0, slow = 1'b0, load_en = 1'b0;
  string_unit_pkg::operands_s ops = '0;
  string_unit_pkg::flags_s flags;
  logic [9:0] load_addr = 10'h000, peek_addr = 10'h000;
  logic [7:0] load_data = 8'h00, peek_data, mem_wdata, mem_rdata;
  logic busy, done, ill, first_part_done, mem_req, mem_we, mem_ack;
  logic [31:0] r0, r1, r2, r3, r4, r5, mem_addr;
  int n_errors = 0;
  int num_checks = 0;
  string_compare_translate_unit DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .start_in(start), .operands_in(ops), .resume_in(resume), .interrupt_pending_in(intr),
    .busy_out(busy), .done_out(done), .illegal_op_out(ill), .first_part_done_out(first_part_done),
    .flags_out(flags), .r0_out(r0), .r1_out(r1), .r2_out(r2), .r3_out(r3), .r4_out(r4),
    .r5_out(r5), .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack));
  string_mem_model mem_model (.clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .req_in(mem_req), .we_in(mem_we), .addr_in(mem_addr), .wdata_in(mem_wdata),
    .rdata_out(mem_rdata), .ack_out(mem_ack), .slow_in(slow), .load_en_in(load_en),
    .load_addr_in(load_addr), .load_data_in(load_data), .peek_addr_in(peek_addr),
    .peek_data_out(peek_data));
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic bad(input string msg);
    n_errors++;
    $display("BAD t=%0t %s", $time, msg);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask
  task automatic chk_flags(input logic [3:0] exp);
    num_checks++;
    if (flags !== exp) bad($sformatf("flags nzvc got %b exp %b", flags, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) bad($sformatf("%s got %b", what, got));
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic load(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    load_en <= 1'b1;
    load_addr <= a;
    load_data <= d;
  endtask
  task automatic chk_mem(input logic [9:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    peek_addr <= a;
    #1;
    chk_word({24'h0, peek_data}, {24'h0, exp}, "memory byte");
  endtask
  // one instruction; optionally interrupted after a few cycles and resumed
  task automatic go(input logic [7:0] opc, input logic [15:0] l1, input logic [31:0] a1,
      input logic [15:0] l2, input logic [31:0] a2, input logic [7:0] aux, input bit irq);
    int k;
    @(posedge ref_clk_in);
    start <= 1'b1;
    ops <= '{opc, l1, a1, l2, a2, 32'h100, aux};
    @(posedge ref_clk_in);
    start <= 1'b0;
    if (irq) begin
      repeat (6) @(posedge ref_clk_in);
      intr <= 1'b1;
      k = 0;
      while (first_part_done !== 1'b1 && k < 200) begin
        @(posedge ref_clk_in);
        #1;
        k++;
      end
      chk_bit(busy, 1'b0, "busy while interrupted");
      @(posedge ref_clk_in);
      intr <= 1'b0;
      resume <= 1'b1;
      @(posedge ref_clk_in);
      resume <= 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    chk_bit(done, 1'b1, "completion pulse");
    chk_bit(first_part_done, 1'b0, "first part done after completion");
  endtask
  task automatic res(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2,
      input logic [31:0] e3, input logic [3:0] ef);
    chk_word(r0, e0, "r0");
    chk_word(r1, e1, "r1");
    chk_word(r2, e2, "r2");
    chk_word(r3, e3, "r3");
    chk_flags(ef);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 256; i++) load(10'h100 + 10'(i), 8'(i + 1));
    for (int i = 0; i < 4; i++) load(10'h200 + 10'(i), 8'h10 + 8'(i));
    for (int i = 0; i < 6; i++) load(10'h300 + 10'(i), 8'hEE);
    load(10'h280, 8'h10);
    load(10'h281, 8'h11);
    load(10'h282, 8'h90);
    load(10'h283, 8'h13);
    load(10'h2C0, 8'h10);
    load(10'h2C1, 8'h11);
    load(10'h2C2, 8'h20);
    load(10'h2C3, 8'h20);
    @(posedge ref_clk_in);
    load_en <= 1'b0;
    // translate: escape on third byte, then interrupted run of the same case
    for (int j = 0; j < 2; j++) begin
      go(8'h2F, 16'h4, 32'h200, 16'h6, 32'h300, 8'h13, j == 1);
      res(32'h2, 32'h202, 32'h0, 32'h100, 4'b0011);
      chk_word(r4, 32'h4, "r4");
      chk_word(r5, 32'h302, "r5");
      chk_mem(10'h300, 8'h11);
      chk_mem(10'h301, 8'h12);
      chk_mem(10'h302, 8'hEE);
    end
    slow <= 1'b1;
    go(8'h2F, 16'h4, 32'h200, 16'h6, 32'h300, 8'hFF, 1'b0);
    res(32'h0, 32'h204, 32'h0, 32'h100, 4'b0001);
    chk_word(r4, 32'h2, "r4");
    chk_word(r5, 32'h304, "r5");
    chk_mem(10'h303, 8'h14);
    slow <= 1'b0;
    go(8'h2F, 16'h4, 32'h200, 16'h2, 32'h300, 8'hFF, 1'b0);
    res(32'h2, 32'h202, 32'h0, 32'h100, 4'b0000);
    chk_word(r4, 32'h0, "r4");
    chk_word(r5, 32'h302, "r5");
    // three-operand compares: unsigned less, signed less, equal, empty
    go(8'h29, 16'h4, 32'h200, 16'h0, 32'h280, 8'h00, 1'b0);
    res(32'h2, 32'h202, 32'h2, 32'h282, 4'b0001);
    go(8'h29, 16'h4, 32'h280, 16'h0, 32'h200, 8'h00, 1'b0);
    res(32'h2, 32'h282, 32'h2, 32'h202, 4'b1000);
    go(8'h29, 16'h4, 32'h200, 16'h0, 32'h200, 8'h00, 1'b0);
    res(32'h0, 32'h204, 32'h0, 32'h204, 4'b0100);
    go(8'h29, 16'h0, 32'h200, 16'h0, 32'h280, 8'h00, 1'b0);
    res(32'h0, 32'h200, 32'h0, 32'h280, 4'b0100);
    // five-operand compares with fill padding
    go(8'h2D, 16'h2, 32'h200, 16'h4, 32'h2C0, 8'h20, 1'b0);
    res(32'h0, 32'h202, 32'h0, 32'h2C4, 4'b0100);
    go(8'h2D, 16'h2, 32'h200, 16'h4, 32'h2C0, 8'h21, 1'b0);
    res(32'h0, 32'h202, 32'h2, 32'h2C2, 4'b0000);
    // class scan and span: stop found, run out, empty string
    go(8'h2A, 16'h4, 32'h200, 16'h0, 32'h0, 8'h04, 1'b0);
    res(32'h1, 32'h203, 32'h0, 32'h100, 4'b0000);
    go(8'h2A, 16'h4, 32'h200, 16'h0, 32'h0, 8'h80, 1'b0);
    res(32'h0, 32'h204, 32'h0, 32'h100, 4'b0100);
    go(8'h2B, 16'h4, 32'h200, 16'h0, 32'h0, 8'h10, 1'b0);
    res(32'h0, 32'h204, 32'h0, 32'h100, 4'b0100);
    go(8'h2B, 16'h4, 32'h200, 16'h0, 32'h0, 8'h80, 1'b0);
    res(32'h4, 32'h200, 32'h0, 32'h100, 4'b0000);
    go(8'h2A, 16'h0, 32'h200, 16'h0, 32'h0, 8'h04, 1'b0);
    res(32'h0, 32'h200, 32'h0, 32'h100, 4'b0100);
    // unknown opcode is refused with a pulse
    @(posedge ref_clk_in);
    start <= 1'b1;
    ops.opcode <= 8'h28;
    @(posedge ref_clk_in);
    start <= 1'b0;
    #1;
    chk_bit(ill, 1'b1, "illegal opcode pulse");
    @(posedge ref_clk_in);
    #1;
    chk_bit(busy, 1'b0, "busy after refused opcode");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    bad("timeout");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verif/string_mem_model.sv
// byte memory standing on the far side of the string unit's memory port
// assumes one request held until ack; the bench preloads and peeks bytes directly
`timescale 1ns/100ps
`default_nettype none
module string_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // unit side
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [31:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic ack_out,
  // bench side
  input wire logic slow_in,
  input wire logic load_en_in,
  input wire logic [9:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  input wire logic [9:0] peek_addr_in,
  output logic [7:0] peek_data_out
);
  logic [7:0] mem [0:1023];
  logic [1:0] wait_cnt;
  logic [7:0] last;
  // ack after zero or two wait cycles; byte-wide, lowest address first
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      wait_cnt <= 2'h0;
      last <= 8'h00;
    end else begin
      ack_out <= 1'b0;
      if (load_en_in) mem[load_addr_in] <= load_data_in;
      if (req_in && !ack_out) begin
        if (slow_in && wait_cnt != 2'h2) wait_cnt <= wait_cnt + 2'h1;
        else begin
          ack_out <= 1'b1;
          wait_cnt <= 2'h0;
        end
      end
      if (ack_out && req_in && we_in) mem[addr_in[9:0]] <= wdata_in;
      if (ack_out) last <= rdata_out;
    end
  end
  // outside an ack the data lines show the inverse of the last byte
  assign rdata_out = ack_out ? mem[addr_in[9:0]] : ~last;
  assign peek_data_out = mem[peek_addr_in];
endmodule
`default_nettype wire
